// ---- adcmux_pkg.sv ----
// Shared constants and types for the converter mux and readback control
package adcmux_pkg;
	localparam int unsigned MCLK_PERIOD_NS = 10;
	localparam int unsigned INSTR_BITS = 8;
	localparam int unsigned RESULT_BITS = 13;
	localparam int unsigned SAMPLE_BITS = 12;
	localparam int unsigned FRAME_BITS = 14;
	localparam int unsigned CONV_CYCLES = 16;
	localparam logic [4:0] INSTR_LAST_BIT = 5'h07;
	localparam logic [4:0] FRAME_LAST = 5'h0e;

	// Instruction field positions, first serial bit is bit 0
	localparam int unsigned IB_SINGLE = 0;
	localparam int unsigned IB_CHAN_LO = 1;
	localparam int unsigned IB_PAIR_HI = 2;
	localparam int unsigned IB_POLARITY = 3;

	// APB byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_RESULT = 8'h0c;
	localparam logic [7:0] OFS_LAST_INSTR = 8'h10;

	// Field positions
	localparam int unsigned CTRL_ENABLE = 0;
	localparam int unsigned CTRL_START = 1;
	localparam int unsigned ST_READY = 0;
	localparam int unsigned ST_BUSY = 1;
	localparam int unsigned ST_FRAME = 2;
	localparam int unsigned ST_SINGLE = 3;
	localparam int unsigned ST_TAP_ONE = 4;
	localparam int unsigned ST_TAP_TWO = 7;
	localparam int unsigned ST_ONE_POS = 10;
	localparam int unsigned ST_PENDING = 11;

	// Values after reset
	localparam logic RST_ENABLE = 1'h1;
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [2:0] RST_SYNC = 3'h6;

	typedef struct packed {
		logic single;
		logic one_pos;
		logic [2:0] tap_one;
		logic [2:0] tap_two;
	} mux_sel_t;

	// Pair 0/1 with input one positive, so the even/odd pair check holds from reset on
	localparam mux_sel_t RST_MUX = 8'h41;
endpackage

// ---- adc_convert_core.sv ----
// Conversion timer and signed result formatting
`timescale 1ns/1ps
module adc_convert_core #(
	parameter int unsigned CYCLES = adcmux_pkg::CONV_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_start,
	input wire logic i_single,
	input wire logic i_one_pos,
	input wire logic [11:0] i_input_one,
	input wire logic [11:0] i_input_two,
	output logic o_busy,
	output logic o_done,
	output logic [12:0] o_result
);
	typedef enum logic {CORE_IDLE, CORE_RUN} core_state_t;
	core_state_t state_q;
	logic [15:0] cnt_q;
	logic [11:0] pos_q;
	logic [11:0] neg_q;
	logic single_q;
	logic signed [13:0] diff;

	// Sampled and held at start so the result matches the acquisition instant
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pos_q <= 12'h000;
			neg_q <= 12'h000;
			single_q <= 1'b0;
		end else if (i_start && state_q == CORE_IDLE) begin
			pos_q <= i_one_pos ? i_input_one : i_input_two;
			neg_q <= i_one_pos ? i_input_two : i_input_one;
			single_q <= i_single;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q <= CORE_IDLE;
			cnt_q <= 16'h0000;
		end else begin
			unique case (state_q)
				CORE_IDLE: begin
					if (i_start) begin
						state_q <= CORE_RUN;
						cnt_q <= 16'(CYCLES - 1);
					end
				end
				CORE_RUN: begin
					if (cnt_q == 16'h0000) begin
						state_q <= CORE_IDLE;
					end else begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
			endcase
		end
	end

	assign diff = $signed({2'b00, pos_q}) - $signed({2'b00, neg_q});

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_done <= 1'b0;
			o_result <= 13'h0000;
		end else begin
			o_done <= state_q == CORE_RUN && cnt_q == 16'h0000;
			if (state_q == CORE_RUN && cnt_q == 16'h0000) begin
				if (single_q && diff < 0) begin
					o_result <= 13'h0000;
				end else if (diff > 14'sd4095) begin
					o_result <= 13'h0fff;
				end else if (diff < -14'sd4096) begin
					o_result <= 13'h1000;
				end else begin
					o_result <= diff[12:0];
				end
			end
		end
	end

	assign o_busy = state_q == CORE_RUN;

	AST_NEG_CODE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_done && !single_q) |-> (o_result[12] == (neg_q > pos_q)))
		else $error("Sign bit does not follow input order");

	AST_SE_SIGN_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_done && single_q) |-> (o_result[12] == 1'b0))
		else $error("Single-ended result has sign set");
endmodule // adc_convert_core

// ---- adc_mux_readback.sv ----
// Mux routing, serial link and stored-result readback control with APB registers
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module adc_mux_readback #(
	parameter int unsigned CONV_CYCLES = adcmux_pkg::CONV_CYCLES
) (
	input wire logic I_MCLK,
	input wire logic I_RST_B,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_SCLK,
	input wire logic I_CS_B,
	input wire logic I_SERIAL_INSTRUCTION_IN,
	input wire logic I_CONV_HOLD,
	output logic O_DO,
	output logic O_OUTPUT_READY_FLAG_B,
	output logic [2:0] O_MUX_TAP_ONE_SEL,
	output logic [2:0] O_MUX_TAP_TWO_SEL,
	output logic O_MUX_TAP_TWO_COMMON,
	output logic O_CONVERTER_INPUT_ONE_POS,
	input wire logic [11:0] I_CONVERTER_INPUT_ONE,
	input wire logic [11:0] I_CONVERTER_INPUT_TWO
);
	function automatic adcmux_pkg::mux_sel_t decode_instr(input logic [7:0] ins);
		adcmux_pkg::mux_sel_t m;
		m.single = ins[adcmux_pkg::IB_SINGLE];
		if (m.single) begin
			m.tap_one = ins[adcmux_pkg::IB_POLARITY:adcmux_pkg::IB_CHAN_LO];
			m.tap_two = 3'h0;
			m.one_pos = 1'b1;
		end else begin
			m.tap_one = {ins[adcmux_pkg::IB_PAIR_HI:adcmux_pkg::IB_CHAN_LO], 1'b0};
			m.tap_two = {ins[adcmux_pkg::IB_PAIR_HI:adcmux_pkg::IB_CHAN_LO], 1'b1};
			m.one_pos = ~ins[adcmux_pkg::IB_POLARITY];
		end
		return m;
	endfunction

	logic link_rst_b;
	logic [4:0] bit_cnt_q;
	logic [7:0] shin_q;
	logic [11:0] dosh_q;
	logic do_q;
	logic [7:0] instr_word_q;
	logic instr_tgl_q;
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic cs_prev_q;
	logic tgl_seen_q;
	logic instr_got_q;
	logic conv_low_seen_q;
	logic [7:0] last_instr_q;
	logic frame_start;
	logic frame_end;
	logic link_start;
	logic start_q;
	logic [7:0] start_instr_q;
	adcmux_pkg::mux_sel_t mux_q;
	logic core_busy;
	logic core_done;
	logic [12:0] core_result;
	logic [12:0] hold_q;
	logic pending_q;
	logic hold_load;
	logic ready_b_q;
	logic enable_q;
	logic sw_start_q;
	logic [7:0] cfg_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] rd_data;
	logic rd_hit;
	logic apb_write;

	// Link logic is cleared by the frame's own chip select; SCLK may stop between frames
	assign link_rst_b = I_RST_B & ~I_CS_B;

	always_ff @(posedge I_SCLK or negedge link_rst_b) begin
		if (!link_rst_b) begin
			bit_cnt_q <= 5'h00;
			shin_q <= 8'h00;
			dosh_q <= 12'h000;
			do_q <= 1'b0;
		end else begin
			if (bit_cnt_q != adcmux_pkg::FRAME_LAST) begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
			end
			if (bit_cnt_q <= adcmux_pkg::INSTR_LAST_BIT) begin
				shin_q <= {I_SERIAL_INSTRUCTION_IN, shin_q[7:1]};
			end
			// every frame reloads the stored result
			if (bit_cnt_q == 5'h00) begin
				do_q <= hold_q[12];
				dosh_q <= hold_q[11:0];
			end else begin
				do_q <= dosh_q[11];
				dosh_q <= {dosh_q[10:0], 1'b0};
			end
		end
	end

	// Word stays put until the next frame's eighth bit, long after the toggle is seen
	always_ff @(posedge I_SCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			instr_word_q <= 8'h00;
			instr_tgl_q <= 1'b0;
		end else if (!I_CS_B && bit_cnt_q == adcmux_pkg::INSTR_LAST_BIT) begin
			instr_word_q <= {I_SERIAL_INSTRUCTION_IN, shin_q[7:1]};
			instr_tgl_q <= ~instr_tgl_q;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			sync1_q <= adcmux_pkg::RST_SYNC;
			sync2_q <= adcmux_pkg::RST_SYNC;
			cs_prev_q <= 1'b1;
			tgl_seen_q <= 1'b0;
		end else begin
			sync1_q <= {I_CS_B, I_CONV_HOLD, instr_tgl_q};
			sync2_q <= sync1_q;
			cs_prev_q <= sync2_q[2];
			tgl_seen_q <= sync2_q[0];
		end
	end

	assign frame_start = cs_prev_q && !sync2_q[2];
	assign frame_end = !cs_prev_q && sync2_q[2];

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			instr_got_q <= 1'b0;
			conv_low_seen_q <= 1'b0;
			last_instr_q <= 8'h00;
		end else begin
			if (frame_start) begin
				instr_got_q <= 1'b0;
				conv_low_seen_q <= 1'b0;
			end else begin
				if (tgl_seen_q != sync2_q[0]) begin
					instr_got_q <= 1'b1;
					last_instr_q <= instr_word_q;
				end
				if (!sync2_q[2] && !sync2_q[1]) begin
					conv_low_seen_q <= 1'b1;
				end
			end
		end
	end

	// pin high throughout means readback only
	assign link_start = frame_end && instr_got_q && conv_low_seen_q && enable_q && !core_busy;

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			start_q <= 1'b0;
			start_instr_q <= 8'h00;
			mux_q <= adcmux_pkg::RST_MUX;
		end else begin
			start_q <= (link_start || (sw_start_q && !core_busy)) && !start_q;
			if (link_start && !start_q) begin
				start_instr_q <= last_instr_q;
				mux_q <= decode_instr(last_instr_q);
			end else if (sw_start_q && !core_busy && !start_q) begin
				start_instr_q <= cfg_q;
				mux_q <= decode_instr(cfg_q);
			end
		end
	end

	adc_convert_core #(
		.CYCLES(CONV_CYCLES)
	) u_core (
		.i_clk(I_MCLK),
		.i_rst_b(I_RST_B),
		.i_start(start_q),
		.i_single(mux_q.single),
		.i_one_pos(mux_q.one_pos),
		.i_input_one(I_CONVERTER_INPUT_ONE),
		.i_input_two(I_CONVERTER_INPUT_TWO),
		.o_busy(core_busy),
		.o_done(core_done),
		.o_result(core_result)
	);

	// only a finished conversion replaces the stored word, never mid-frame
	assign hold_load = pending_q && sync2_q[2];

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			pending_q <= 1'b0;
			hold_q <= 13'h0000;
		end else begin
			if (core_done) begin
				pending_q <= 1'b1;
			end else if (hold_load) begin
				pending_q <= 1'b0;
			end
			if (hold_load) begin
				hold_q <= core_result;
			end
		end
	end

	// flag rises at frame start, stored word untouched
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			ready_b_q <= 1'b1;
		end else if (hold_load) begin
			ready_b_q <= 1'b0;
		end else if (frame_start) begin
			ready_b_q <= 1'b1;
		end
	end

	assign apb_write = I_PSEL && I_PENABLE && pready_q && I_PWRITE;

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			enable_q <= adcmux_pkg::RST_ENABLE;
			sw_start_q <= 1'b0;
			cfg_q <= adcmux_pkg::RST_CFG;
		end else begin
			if (sw_start_q && !core_busy && !start_q && !link_start) begin
				sw_start_q <= 1'b0;
			end
			if (apb_write && I_PADDR == adcmux_pkg::OFS_CTRL) begin
				enable_q <= I_PWDATA[adcmux_pkg::CTRL_ENABLE];
				if (I_PWDATA[adcmux_pkg::CTRL_START]) begin
					sw_start_q <= 1'b1;
				end
			end
			if (apb_write && I_PADDR == adcmux_pkg::OFS_CFG) begin
				cfg_q <= I_PWDATA[7:0];
			end
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (I_PADDR)
			adcmux_pkg::OFS_CTRL: rd_data[adcmux_pkg::CTRL_START:0] = {sw_start_q, enable_q};
			adcmux_pkg::OFS_CFG: rd_data[7:0] = cfg_q;
			adcmux_pkg::OFS_STATUS: begin
				rd_data[adcmux_pkg::ST_READY] = ~ready_b_q;
				rd_data[adcmux_pkg::ST_BUSY] = core_busy;
				rd_data[adcmux_pkg::ST_FRAME] = ~sync2_q[2];
				rd_data[adcmux_pkg::ST_SINGLE] = mux_q.single;
				rd_data[adcmux_pkg::ST_TAP_ONE +: 3] = mux_q.tap_one;
				rd_data[adcmux_pkg::ST_TAP_TWO +: 3] = mux_q.tap_two;
				rd_data[adcmux_pkg::ST_ONE_POS] = mux_q.one_pos;
				rd_data[adcmux_pkg::ST_PENDING] = pending_q;
			end
			adcmux_pkg::OFS_RESULT: rd_data[12:0] = hold_q;
			adcmux_pkg::OFS_LAST_INSTR: rd_data[7:0] = last_instr_q;
			default: rd_hit = 1'b0;
		endcase
	end

	// Zero wait states: answer prepared in the setup cycle
	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= I_PSEL && !I_PENABLE;
			if (I_PSEL && !I_PENABLE) begin
				prdata_q <= I_PWRITE ? 32'h0000_0000 : rd_data;
				pslverr_q <= !rd_hit;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	assign O_PRDATA = prdata_q;
	assign O_PREADY = pready_q;
	assign O_PSLVERR = pslverr_q;
	assign O_DO = do_q;
	assign O_OUTPUT_READY_FLAG_B = ready_b_q;
	assign O_MUX_TAP_ONE_SEL = mux_q.tap_one;
	assign O_MUX_TAP_TWO_SEL = mux_q.tap_two;
	assign O_MUX_TAP_TWO_COMMON = mux_q.single;
	assign O_CONVERTER_INPUT_ONE_POS = mux_q.one_pos;

	AST_READBACK_NO_START: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		(frame_end && !conv_low_seen_q && !sw_start_q) |=> !start_q)
		else $error("Conversion started by a readback frame");

	AST_FLAG_AFTER_LOAD: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		hold_load |=> (!ready_b_q && hold_q == $past(core_result)))
		else $error("Ready flag or stored word wrong after load");

	AST_HOLD_ONLY_ON_DONE: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		!$stable(hold_q) |-> $past(pending_q) && $past(sync2_q[2]))
		else $error("Stored word changed without a finished conversion");

	AST_DIFF_PAIRS: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		!mux_q.single |-> (mux_q.tap_one[0] == 1'b0 && mux_q.tap_two == {mux_q.tap_one[2:1], 1'b1}))
		else $error("Differential pair not even with next odd");

	AST_SE_ROUTE: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		mux_q.single |-> mux_q.one_pos)
		else $error("Single-ended route without input one positive");

	AST_RESELECT: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
		start_q |-> mux_q == decode_instr(start_instr_q) ##1 (core_busy [*3]))
		else $error("Mux not re-selected for the new conversion");
endmodule // adc_mux_readback

// ---- link_host.sv ----
// Behavioural host model driving the chip-selected serial link
`timescale 1ns/1ps
module link_host (
	input wire logic i_req,
	input wire logic [7:0] i_instr,
	input wire logic i_hold,
	input wire logic i_do,
	output logic o_ack,
	output logic [12:0] o_word,
	output logic o_sclk,
	output logic o_cs_b,
	output logic o_di,
	output logic o_conv_hold
);
	localparam real HALF_NS = 32.0;
	// One frame: 8 instruction bits in, 13 result bits out, 14 edges
	task automatic frame;
		o_conv_hold = i_hold;
		o_cs_b = 1'b0;
		for (int k = 0; k < 14; k++) begin
			o_di = (k < 8) ? i_instr[k] : ~o_di;
			#HALF_NS;
			if (k >= 1) begin
				o_word[13 - k] = i_do;
			end
			o_sclk = 1'b1;
			#HALF_NS;
			o_sclk = 1'b0;
		end
		#HALF_NS;
		o_cs_b = 1'b1;
		o_conv_hold = 1'b1;
		// Gap well above the 4 cycle minimum between frames
		#(8 * HALF_NS);
	endtask
	initial begin
		o_ack = 1'b0;
		o_word = 13'h0000;
		o_sclk = 1'b0;
		o_cs_b = 1'b1;
		o_di = 1'b0;
		o_conv_hold = 1'b1;
		#3.7;
		forever begin
			if (i_req !== 1'b1 || o_ack) begin
				if (i_req !== 1'b1) begin
					o_ack = 1'b0;
				end
				// Idle data line keeps moving so no stale bit can pass
				#HALF_NS o_di = ~o_di;
			end else begin
				frame;
				o_ack = 1'b1;
			end
		end
	end
endmodule // link_host

// ---- adc_mux_readback_bench.sv ----
// Self-checking bench for the converter mux and readback control
`timescale 1ns/1ps
module adc_mux_readback_bench;
	localparam int CONV = 4;
	localparam int LIMIT = 20000;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, sclk, cs_b, di, hold_pin, do_bit, flag_b, common, one_pos, ack;
	logic [2:0] tap_one, tap_two;
	logic [11:0] in_one = 12'h000;
	logic [11:0] in_two = 12'h000;
	logic req = 1'b0;
	logic hold = 1'b1;
	logic [7:0] instr = 8'h00;
	logic [12:0] word, stored;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	initial begin
		forever #5 mclk = ~mclk;
	end
	adc_mux_readback #(.CONV_CYCLES(CONV)) adc_mux_readback_inst (.I_MCLK(mclk), .I_RST_B(rst_b), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCLK(sclk), .I_CS_B(cs_b), .I_SERIAL_INSTRUCTION_IN(di),
		.I_CONV_HOLD(hold_pin), .O_DO(do_bit), .O_OUTPUT_READY_FLAG_B(flag_b), .O_MUX_TAP_ONE_SEL(tap_one),
		.O_MUX_TAP_TWO_SEL(tap_two), .O_MUX_TAP_TWO_COMMON(common), .O_CONVERTER_INPUT_ONE_POS(one_pos),
		.I_CONVERTER_INPUT_ONE(in_one), .I_CONVERTER_INPUT_TWO(in_two));
	link_host link_host_inst (.i_req(req), .i_instr(instr), .i_hold(hold), .i_do(do_bit), .o_ack(ack),
		.o_word(word), .o_sclk(sclk), .o_cs_b(cs_b), .o_di(di), .o_conv_hold(hold_pin));
	task automatic end_of_test;
		if (failures == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			end_of_test;
		end
	end
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_mux(input logic [7:0] ins);
		if (ins[0]) begin
			check_val({tap_one, common, one_pos}, {ins[3:1], 2'b11});
		end else begin
			check_val({tap_one, tap_two, common, one_pos}, {ins[2:1], 1'b0, ins[2:1], 2'b10, ~ins[3]});
		end
	endtask
	// Expected code worked out independently of the design
	function automatic logic [12:0] code(input logic [7:0] ins, input logic [11:0] a, input logic [11:0] b);
		if (ins[0]) begin
			return (a > b) ? {1'b0, a - b} : 13'h0000;
		end
		return ins[3] ? ({1'b0, b} - {1'b0, a}) : ({1'b0, a} - {1'b0, b});
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic link(input logic [7:0] ins, input logic h);
		@(posedge mclk);
		instr <= ins;
		hold <= h;
		req <= 1'b1;
		while (ack !== 1'b1) @(posedge mclk);
		req <= 1'b0;
		while (ack !== 1'b0) @(posedge mclk);
	endtask
	task automatic convert(input logic [7:0] ins, input logic [11:0] a, input logic [11:0] b);
		@(posedge mclk);
		in_one <= a;
		in_two <= b;
		link(ins, 1'b0);
		check_val(word, stored);
		while (flag_b !== 1'b0) @(posedge mclk);
		check_mux(ins);
		stored = code(ins, a, b);
		apb(1'b0, adcmux_pkg::OFS_RESULT, 32'h0);
		check_val(rd, stored);
	endtask
	task automatic readback(input logic [7:0] ins);
		@(posedge mclk);
		in_one <= ~in_one;
		link(~ins, 1'b1);
		check_mux(ins);
		check_val(word, stored);
		check_val(flag_b, 1'b1);
		apb(1'b0, adcmux_pkg::OFS_LAST_INSTR, 32'h0);
		check_val(rd, {24'h0, ~ins});
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		check_val({do_bit, flag_b, tap_one, tap_two, common, one_pos}, {2'b01, 6'h01, 2'b01});
		apb(1'b0, 8'h40, 32'h0);
		check_val({rd[30:0], er}, 32'h1);
		stored = 13'h0000;
		for (int c = 0; c < 8; c++) begin
			convert({4'h0, c[2:0], 1'b1}, {c[2:0], 9'h1ff}, (c == 3) ? 12'hfff : 12'h000);
		end
		for (int p = 0; p < 8; p++) begin
			convert({4'h0, p[2], p[1:0], 1'b0}, {p[1:0], 10'h000}, 12'hfff);
		end
		readback(8'h0e);
		readback(8'h0e);
		// Link conversions disabled: a convert frame must leave result and mux alone
		apb(1'b1, adcmux_pkg::OFS_CTRL, 32'h00000000);
		link(8'h01, 1'b0);
		check_val({word, flag_b}, {stored, 1'b1});
		check_mux(8'h0e);
		@(posedge mclk);
		in_one <= 12'h5a5;
		in_two <= 12'h0a5;
		apb(1'b1, adcmux_pkg::OFS_CFG, 32'h0000000f);
		apb(1'b1, adcmux_pkg::OFS_CTRL, 32'h00000003);
		while (flag_b !== 1'b0) @(posedge mclk);
		check_mux(8'h0f);
		stored = 13'h0500;
		apb(1'b0, adcmux_pkg::OFS_RESULT, 32'h0);
		check_val(rd, stored);
		readback(8'h0f);
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		apb(1'b1, adcmux_pkg::OFS_CFG, 32'h00000003);
		apb(1'b1, adcmux_pkg::OFS_CTRL, 32'h00000003);
		while (flag_b !== 1'b0) @(posedge mclk);
		check_mux(8'h03);
		apb(1'b0, adcmux_pkg::OFS_RESULT, 32'h0);
		check_val(rd, {19'h0, code(8'h03, 12'ha5a, 12'h0a5)});
		end_of_test;
	end
endmodule // adc_mux_readback_bench
